// file: design/two_wire_bus_master_core.sv
// Two-wire bus master core: bus state tracker, rate generator and address phase.
// Behaviour
// - Lines are only pulled low or released, never driven high.
// - After Start the master sends seven address bits plus a direction bit.
// - A packet is nine bit periods: eight data bits, then acknowledge.
// - The master ends its transaction with a Stop condition.
// - Software writes own address, enables target; target waits for matching address.
// - Write or read flag set by the address phase holds SCL low; clearing releases it. A collision sets the write flag without holding SCL.
// - SCL rate is clock over ten plus twice divider plus rise time.
// - Low phase lasts divider plus five cycles, fall time included.
// - High phase counting starts only once SCL is sensed high.
// - Bus state tracking runs whenever the master is enabled.
// - Bus state is Unknown after reset, enable and disable.
// - Writing one to the bus state field forces Idle; others ignored.
// - First Stop or configured inactivity timeout moves the state to Idle.
// - Foreign Start in Idle gives Busy; Stop or timeout returns Idle.
// - Own Start gives Owner; own Stop Idle; collision gives Busy.
// - Writing target address starts a transaction and copies into data.
// - Start waits while the bus is Busy, then address shifts out.
// - Acknowledged write address sets write flag, clears ack flag, holds SCL.
// - Acknowledged read address clears ack flag and holds SCL low.
// - Unacknowledged address sets write and ack flags and holds SCL.
`timescale 1ns/1ns
`default_nettype none
module two_wire_bus_master_core
  import two_wire_pkg::*;
#(
  parameter int unsigned TIMEOUT_BASE_CYCLES = TIMEOUT_BASE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  // ==========================================================================
  // Register bus slave.
  function automatic logic reg_known(input logic [ADDR_W-1:0] a);
    reg_known = (a == OFF_CTRL) || (a == OFF_MCTRL) || (a == OFF_MASTER_STATUS_REGISTER) || (a == OFF_MRATE) ||
                (a == OFF_MASTER_TARGET_ADDRESS) || (a == OFF_MASTER_DATA_REGISTER) || (a == OFF_OWNADDR) || (a == OFF_TCTRL) ||
                (a == OFF_MCMD);
  endfunction : reg_known

  logic aw_full_r, w_full_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic wr_fire, wr_en;
  logic [7:0] ctrl_r, mctrl_r, mrate_r, master_target_address_r, master_data_register_r, own_r;
  logic tgt_en_r, tgt_match_r;
  status_t status;

  assign awready = !aw_full_r && !bvalid_r;
  assign wready = !w_full_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
  assign wr_en = wr_fire && w_lane_r && reg_known(aw_addr_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= AXI_OKAY;
      aw_addr_r <= '0;
      w_data_r <= REG_RESET;
      w_lane_r <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        w_data_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
      end
      if (wr_fire) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= reg_known(aw_addr_r) ? AXI_OKAY : AXI_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= AXI_OKAY;
      rdata_r <= '0;
    end else if (arvalid && arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= reg_known(araddr) ? AXI_OKAY : AXI_SLVERR;
      if (araddr == OFF_CTRL) begin
        rdata_r <= {24'h0000_00, ctrl_r};
      end else if (araddr == OFF_MCTRL) begin
        rdata_r <= {24'h0000_00, mctrl_r};
      end else if (araddr == OFF_MASTER_STATUS_REGISTER) begin
        rdata_r <= {24'h0000_00, status};
      end else if (araddr == OFF_MRATE) begin
        rdata_r <= {24'h0000_00, mrate_r};
      end else if (araddr == OFF_MASTER_TARGET_ADDRESS) begin
        rdata_r <= {24'h0000_00, master_target_address_r};
      end else if (araddr == OFF_MASTER_DATA_REGISTER) begin
        rdata_r <= {24'h0000_00, master_data_register_r};
      end else if (araddr == OFF_OWNADDR) begin
        rdata_r <= {24'h0000_00, own_r};
      end else if (araddr == OFF_TCTRL) begin
        rdata_r <= {24'h0000_00, tgt_match_r, 6'h00, tgt_en_r};
      end else begin
        rdata_r <= '0;
      end
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  logic wr_master_target_address, wr_master_data_register, wr_status, wr_stop;
  assign wr_master_target_address = wr_en && (aw_addr_r == OFF_MASTER_TARGET_ADDRESS);
  assign wr_master_data_register = wr_en && (aw_addr_r == OFF_MASTER_DATA_REGISTER);
  assign wr_status = wr_en && (aw_addr_r == OFF_MASTER_STATUS_REGISTER);
  assign wr_stop = wr_en && (aw_addr_r == OFF_MCMD) && (w_data_r[1:0] == CMD_STOP);

  // Options are stored before enabling; hold select delays SDA after SCL falls.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= REG_RESET;
      mctrl_r <= REG_RESET;
      mrate_r <= REG_RESET;
      master_target_address_r <= REG_RESET;
      master_data_register_r <= REG_RESET;
      own_r <= REG_RESET;
      tgt_en_r <= 1'b0;
    end else if (wr_en) begin
      if (aw_addr_r == OFF_CTRL) begin
        ctrl_r <= w_data_r;
      end else if (aw_addr_r == OFF_MCTRL) begin
        mctrl_r <= w_data_r;
      end else if (aw_addr_r == OFF_MRATE) begin
        mrate_r <= w_data_r;
      end else if (aw_addr_r == OFF_MASTER_TARGET_ADDRESS) begin
        master_target_address_r <= w_data_r;
        master_data_register_r <= w_data_r;
      end else if (aw_addr_r == OFF_MASTER_DATA_REGISTER) begin
        master_data_register_r <= w_data_r;
      end else if (aw_addr_r == OFF_OWNADDR) begin
        own_r <= w_data_r;
      end else if (aw_addr_r == OFF_TCTRL) begin
        tgt_en_r <= w_data_r[TCTRL_EN_BIT];
      end
    end
  end

  AST_ADDR_COPY: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_master_target_address |=> (master_data_register_r == master_target_address_r) && (master_target_address_r == $past(w_data_r)))
    else $error("Target address was not copied into the data register.");

  // ==========================================================================
  // Pin synchronisers and condition detectors.
  logic scl_meta_r, scl_s_r, sda_meta_r, sda_s_r, scl_prev_r, sda_prev_r;
  logic start_det, stop_det, line_act;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_meta_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_in;
      scl_s_r <= scl_meta_r;
      sda_meta_r <= sda_in;
      sda_s_r <= sda_meta_r;
      scl_prev_r <= scl_s_r;
      sda_prev_r <= sda_s_r;
    end
  end
  assign start_det = scl_s_r && scl_prev_r && sda_prev_r && !sda_s_r;
  assign stop_det = scl_s_r && scl_prev_r && !sda_prev_r && sda_s_r;
  assign line_act = (scl_s_r != scl_prev_r) || (sda_s_r != sda_prev_r);

  // ==========================================================================
  // Master sequencer: start, nine-bit address packet, clock hold and stop.
  logic men;
  logic [8:0] period, hold_cnt;
  mstate_t state_r;
  logic [8:0] cnt_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shreg_r;
  logic scl_low_r, sda_low_r, ack_r, start_req_r, stop_req_r, stretch_r;
  logic tx_bit, last_bit, phase_end, sample, collide, addr_done;

  assign men = mctrl_r[MCTRL_EN_BIT];
  assign period = {1'b0, mrate_r} + PHASE_EXTRA;
  assign hold_cnt = {7'h00, ctrl_r[CTRL_HOLD_LSB +: 2]};
  assign last_bit = (bit_cnt_r == 4'h8);
  assign tx_bit = last_bit ? 1'b1 : shreg_r[~bit_cnt_r[2:0]];
  assign phase_end = (cnt_r == period - 9'h001);
  assign sample = (state_r == M_HIGH) && scl_s_r && (cnt_r == 9'h000);
  assign collide = sample && !last_bit && tx_bit && !sda_s_r;
  assign addr_done = (state_r == M_HIGH) && scl_s_r && phase_end && last_bit;

  // Both lines only ever pull low; the released level comes from the pull-ups.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !scl_low_r;
  assign sda_oe_n = !sda_low_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || !men) begin
      state_r <= M_IDLE;
      cnt_r <= 9'h000;
      bit_cnt_r <= 4'h0;
      shreg_r <= REG_RESET;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      ack_r <= 1'b0;
      start_req_r <= 1'b0;
      stop_req_r <= 1'b0;
    end else begin
      case (state_r)
        M_IDLE: begin
          scl_low_r <= 1'b0;
          sda_low_r <= 1'b0;
          cnt_r <= 9'h000;
          stop_req_r <= 1'b0;
          if (start_req_r && (status.bus_state == BUS_IDLE) && scl_s_r && sda_s_r) begin
            state_r <= M_START;
            sda_low_r <= 1'b1;
            shreg_r <= master_target_address_r;
            start_req_r <= 1'b0;
          end
        end
        M_START: begin
          cnt_r <= cnt_r + 9'h001;
          if (phase_end) begin
            state_r <= M_LOW;
            scl_low_r <= 1'b1;
            cnt_r <= 9'h000;
            bit_cnt_r <= 4'h0;
          end
        end
        M_LOW, M_PREP, M_STOP_LOW: begin
          cnt_r <= cnt_r + 9'h001;
          if (cnt_r == hold_cnt) begin
            sda_low_r <= (state_r == M_LOW) ? !tx_bit : (state_r == M_STOP_LOW);
          end
          if (phase_end) begin
            state_r <= (state_r == M_LOW) ? M_HIGH : ((state_r == M_PREP) ? M_RISE : M_STOP_HIGH);
            scl_low_r <= 1'b0;
            cnt_r <= 9'h000;
          end
        end
        M_HIGH, M_RISE, M_STOP_HIGH: begin
          if (!scl_s_r) begin
            cnt_r <= 9'h000;
          end else if (collide) begin
            state_r <= M_IDLE;
            sda_low_r <= 1'b0;
          end else begin
            cnt_r <= cnt_r + 9'h001;
            if (sample && last_bit) begin
              ack_r <= !sda_s_r;
            end
            if (phase_end) begin
              cnt_r <= 9'h000;
              if (state_r == M_RISE) begin
                state_r <= M_START;
                sda_low_r <= 1'b1;
                shreg_r <= master_target_address_r;
                start_req_r <= 1'b0;
              end else if (state_r == M_STOP_HIGH) begin
                state_r <= M_STOP_END;
                sda_low_r <= 1'b0;
              end else begin
                state_r <= last_bit ? M_HOLD : M_LOW;
                scl_low_r <= 1'b1;
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
        end
        M_HOLD: begin
          scl_low_r <= stretch_r;
          cnt_r <= 9'h000;
          if (stop_req_r) begin
            state_r <= M_STOP_LOW;
            scl_low_r <= 1'b1;
            stop_req_r <= 1'b0;
          end else if (start_req_r) begin
            state_r <= M_PREP;
            scl_low_r <= 1'b1;
          end
        end
        M_STOP_END: begin
          cnt_r <= cnt_r + 9'h001;
          if (phase_end) begin
            state_r <= M_IDLE;
          end
        end
        default: begin
          state_r <= M_IDLE;
        end
      endcase
      if (wr_master_target_address) begin
        start_req_r <= 1'b1;
      end
      if (wr_stop) begin
        stop_req_r <= 1'b1;
      end
    end
  end

  AST_HIGH_WAITS: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == M_HIGH && !scl_s_r) |=> (cnt_r == 9'h000) || (state_r != M_HIGH))
    else $error("High phase counted while SCL was still low.");
  AST_LOW_SPAN: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == M_LOW && $past(state_r) == M_LOW) |-> (cnt_r == $past(cnt_r) + 9'h001) && (cnt_r < period))
    else $error("Low phase count does not run to divider plus five.");
  AST_NINE_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == M_HOLD && $past(state_r) == M_HIGH) |-> $past(bit_cnt_r) == 4'h8)
    else $error("Address packet did not last nine bit periods.");
  AST_START_WAITS: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == M_IDLE && status.bus_state == BUS_BUSY) |=> state_r != M_START)
    else $error("Start issued while the bus was busy.");
  AST_OPEN_DRAIN: assert property (@(posedge aclk) disable iff (!aresetn)
    (scl_out == 1'b0) && (sda_out == 1'b0) && (scl_oe_n == !scl_low_r))
    else $error("A bus line was driven high.");

  // ==========================================================================
  // Status flags; a hardware set wins over a clear in the same cycle.
  logic write_done_r, read_done_r, received_ack_flag_r, arb_lost_r;
  logic write_done_nxt, read_done_nxt;
  logic set_wr, set_rd;
  assign set_wr = (addr_done && (!ack_r || !shreg_r[0])) || collide;
  assign set_rd = addr_done && ack_r && shreg_r[0];

  always_comb begin
    write_done_nxt = write_done_r;
    read_done_nxt = read_done_r;
    if (wr_master_target_address || wr_master_data_register || (wr_status && w_data_r[6])) begin
      write_done_nxt = 1'b0;
    end
    if (wr_master_target_address || (wr_status && w_data_r[7])) begin
      read_done_nxt = 1'b0;
    end
    if (set_wr) begin
      write_done_nxt = 1'b1;
    end
    if (set_rd) begin
      read_done_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_done_r <= 1'b0;
      read_done_r <= 1'b0;
      received_ack_flag_r <= 1'b0;
      arb_lost_r <= 1'b0;
      stretch_r <= 1'b0;
    end else begin
      write_done_r <= write_done_nxt;
      read_done_r <= read_done_nxt;
      if (addr_done) begin
        received_ack_flag_r <= !ack_r;
        stretch_r <= 1'b1;
      end else if (wr_master_target_address || !(write_done_nxt || read_done_nxt)) begin
        stretch_r <= 1'b0;
      end
      if (collide) begin
        arb_lost_r <= 1'b1;
      end else if (wr_master_target_address || (wr_status && w_data_r[3])) begin
        arb_lost_r <= 1'b0;
      end
    end
  end

  AST_NACK_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    (addr_done && !ack_r) |=> write_done_r && received_ack_flag_r && stretch_r)
    else $error("Missing acknowledge did not set write and ack flags.");
  AST_HOLD_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == M_HOLD && $past(state_r) == M_HOLD && stretch_r) |=> !scl_oe_n || state_r != M_HOLD)
    else $error("SCL released while a completion flag was pending.");

  // ==========================================================================
  // Bus state tracker and inactivity timeout.
  bus_state_t bus_state_r;
  logic men_prev_r;
  logic [17:0] idle_cnt_r, tmo_lim;
  logic tmo_hit, force_idle;
  // Only the inactivity figure varies, so one base count scaled by the field serves every setting.
  assign tmo_lim = 18'(TIMEOUT_BASE_CYCLES) * {16'h0000, mctrl_r[MCTRL_TMO_LSB +: 2]};
  // Compare with at least the limit, so a field raised after a long quiet spell still expires.
  assign tmo_hit = (tmo_lim != 18'h0_0000) && (idle_cnt_r >= tmo_lim);
  assign force_idle = wr_status && (w_data_r[1:0] == BUS_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn || line_act) begin
      idle_cnt_r <= 18'h0_0000;
    end else if (!tmo_hit) begin
      idle_cnt_r <= idle_cnt_r + 18'h0_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      men_prev_r <= 1'b0;
      bus_state_r <= BUS_UNKNOWN;
    end else begin
      men_prev_r <= men;
      if (!men || (men != men_prev_r)) begin
        bus_state_r <= BUS_UNKNOWN;
      end else if (force_idle) begin
        bus_state_r <= BUS_IDLE;
      end else if (collide) begin
        bus_state_r <= BUS_BUSY;
      end else if (stop_det) begin
        bus_state_r <= BUS_IDLE;
      end else if (start_det && bus_state_r == BUS_IDLE) begin
        bus_state_r <= (state_r == M_START) ? BUS_OWNER : BUS_BUSY;
      end else if (tmo_hit && (bus_state_r == BUS_BUSY || bus_state_r == BUS_UNKNOWN)) begin
        bus_state_r <= BUS_IDLE;
      end
    end
  end

  assign status = '{read_done: read_done_r, write_done: write_done_r, scl_stretch: stretch_r,
                    received_ack: received_ack_flag_r, arb_lost: arb_lost_r, rsvd: 1'b0, bus_state: bus_state_r};

  AST_UNKNOWN_ON_EN: assert property (@(posedge aclk) disable iff (!aresetn)
    (men != $past(men)) |=> bus_state_r == BUS_UNKNOWN)
    else $error("Enable change did not set the bus state to Unknown.");
  AST_FORCE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (force_idle && men && men_prev_r) |=> bus_state_r == BUS_IDLE)
    else $error("Forcing Idle had no effect.");

  // ==========================================================================
  // Target address watcher: only reports a match, the packet itself is elsewhere.
  logic tgt_busy_r;
  logic [2:0] tgt_cnt_r;
  logic [6:0] tgt_sh_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgt_busy_r <= 1'b0;
      tgt_cnt_r <= 3'h0;
      tgt_sh_r <= 7'h00;
      tgt_match_r <= 1'b0;
    end else begin
      if (wr_en && aw_addr_r == OFF_TCTRL && w_data_r[TCTRL_MATCH_BIT]) begin
        tgt_match_r <= 1'b0;
      end
      if (!tgt_en_r || stop_det) begin
        tgt_busy_r <= 1'b0;
      end else if (start_det) begin
        tgt_busy_r <= 1'b1;
        tgt_cnt_r <= 3'h0;
      end else if (tgt_busy_r && scl_s_r && !scl_prev_r) begin
        tgt_sh_r <= {tgt_sh_r[5:0], sda_s_r};
        tgt_cnt_r <= tgt_cnt_r + 3'h1;
        if (tgt_cnt_r == 3'h7) begin
          tgt_busy_r <= 1'b0;
          if (tgt_sh_r == own_r[7:1]) begin
            tgt_match_r <= 1'b1;
          end
        end
      end
    end
  end
endmodule : two_wire_bus_master_core
`default_nettype wire

// file: include/two_wire_pkg.sv
// Constants, types and register map of the two-wire bus master core.
package two_wire_pkg;
  // ==========================================================================
  // Register map (byte addresses on the register bus).
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_MCTRL = 6'h04;
  localparam logic [5:0] OFF_MASTER_STATUS_REGISTER = 6'h08;
  localparam logic [5:0] OFF_MRATE = 6'h0C;
  localparam logic [5:0] OFF_MASTER_TARGET_ADDRESS = 6'h10;
  localparam logic [5:0] OFF_MASTER_DATA_REGISTER = 6'h14;
  localparam logic [5:0] OFF_OWNADDR = 6'h18;
  localparam logic [5:0] OFF_TCTRL = 6'h1C;
  localparam logic [5:0] OFF_MCMD = 6'h20;
  // ==========================================================================
  // Field positions and values.
  localparam int unsigned CTRL_SETUP_BIT = 4;
  localparam int unsigned CTRL_HOLD_LSB = 2;
  localparam int unsigned CTRL_FMP_BIT = 1;
  localparam int unsigned MCTRL_EN_BIT = 0;
  localparam int unsigned MCTRL_TMO_LSB = 2;
  localparam int unsigned TCTRL_EN_BIT = 0;
  localparam int unsigned TCTRL_MATCH_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] CMD_STOP = 2'b11;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  // ==========================================================================
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [8:0] PHASE_EXTRA = 9'h005;
  localparam int unsigned TIMEOUT_BASE_NS = 50000;
  localparam int unsigned TIMEOUT_BASE_CYC = TIMEOUT_BASE_NS / CLK_PERIOD_NS;
  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    BUS_UNKNOWN = 2'b00,
    BUS_IDLE = 2'b01,
    BUS_BUSY = 2'b10,
    BUS_OWNER = 2'b11
  } bus_state_t;
  typedef enum logic [3:0] {
    M_IDLE = 4'b0000,
    M_START = 4'b0001,
    M_LOW = 4'b0011,
    M_HIGH = 4'b0010,
    M_HOLD = 4'b0110,
    M_PREP = 4'b0111,
    M_RISE = 4'b0101,
    M_STOP_LOW = 4'b0100,
    M_STOP_HIGH = 4'b1100,
    M_STOP_END = 4'b1101
  } mstate_t;
  typedef struct packed {
    logic read_done;
    logic write_done;
    logic scl_stretch;
    logic received_ack;
    logic arb_lost;
    logic rsvd;
    bus_state_t bus_state;
  } status_t;
endpackage : two_wire_pkg

// file: testbench/i2c_target_model.sv
// Behavioural bus target that shifts in the address byte and answers it.
`timescale 1ns/1ns
`default_nettype none
module i2c_target_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  output logic sda_pull,
  output logic [7:0] got
);
  // ==========================================================================
  // Bit counter and acknowledge; the line is only ever pulled low.
  int n;
  initial begin
    sda_pull = 1'b0;
    n = 0;
    got = 8'h00;
  end
  always @(negedge sda) begin
    if (scl) n = 0;
  end
  always @(posedge scl) begin
    if (n < 8) got = {got[6:0], sda};
    n = n + 1;
  end
  // The answer stands for the ninth bit only, then the line is released.
  always @(negedge scl) begin
    sda_pull <= (n == 8) && ack_en;
  end
endmodule : i2c_target_model
`default_nettype wire

// file: testbench/two_wire_bus_master_core_test.sv
// Self-checking bench for the two-wire bus master core.
`timescale 1ns/1ns
`default_nettype none
module two_wire_bus_master_core_test
  import two_wire_pkg::*;
;
  // ==========================================================================
  // Signals and instances.
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid, ack_en = 1'b1, sda_pull, ext_sda = 1'b0;
  logic scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  logic [7:0] got;
  int failures = 0, tests_run = 0;
  always #5 aclk = ~aclk;
  // Both lines have a pull-up, so a released line reads high; ext_sda stands for another master.
  assign scl_in = scl_oe_n;
  assign sda_in = sda_oe_n & ~sda_pull & ~ext_sda;
  two_wire_bus_master_core #(.TIMEOUT_BASE_CYCLES(20)) i_two_wire_bus_master_core (.*);
  i2c_target_model i_i2c_target_model (.scl(scl_in), .sda(sda_in), .ack_en(ack_en), .sda_pull(sda_pull), .got(got));
  // ==========================================================================
  // Register bus tasks and comparison.
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h00_0000, v, 3'b111};
    do begin
      @(negedge aclk);
      {ta, tw, tb, r} = {awready & awvalid, wready & wvalid, bvalid, bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end while (!tb);
  endtask : wr
  task automatic rd(input logic [5:0] a);
    logic ta, tr;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(negedge aclk);
      {ta, tr, d, r} = {arready & arvalid, rvalid, rdata, rresp};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end while (!tr);
  endtask : rd
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic poll(input logic [7:0] m, input logic [7:0] v);
    d = 32'h0000_0000;
    for (int i = 0; i < 1000 && (d[7:0] & m) !== v; i++) rd(OFF_MASTER_STATUS_REGISTER);
  endtask : poll
  // ==========================================================================
  // Scenarios.
  task automatic t_reset_and_force;
    rd(OFF_MASTER_STATUS_REGISTER);
    chk(d, 32'h0000_0000);
    wr(OFF_CTRL, 8'h06);
    wr(OFF_OWNADDR, 8'hA4);
    wr(OFF_TCTRL, 8'h01);
    // A divider of 45 gives a 500 ns low phase, the fast-plus minimum.
    wr(OFF_MRATE, 8'h2D);
    wr(OFF_MCTRL, 8'h01);
    wr(OFF_MASTER_STATUS_REGISTER, 8'h02);
    rd(OFF_MASTER_STATUS_REGISTER);
    chk(d, 32'h0000_0000);
    wr(OFF_MASTER_STATUS_REGISTER, 8'h01);
    chk(r, AXI_OKAY);
    rd(OFF_MASTER_STATUS_REGISTER);
    chk(d, 32'h0000_0001);
    wr(6'h3C, 8'h55);
    chk(r, AXI_SLVERR);
    rd(6'h3C);
    chk(r, AXI_SLVERR);
    chk(d, 32'h0000_0000);
    chk({scl_out, sda_out}, 2'b00);
  endtask : t_reset_and_force
  // One address phase, then a Stop, then the read, write and collision flags are cleared; the ack flag stays.
  // With f set, another master holds the bus first and our Start must wait for its Stop.
  task automatic t_addr(input logic [7:0] b, input logic a, input logic [7:0] e, input logic f);
    ack_en <= a;
    ext_sda <= f;
    repeat (4) @(posedge aclk);
    wr(OFF_MASTER_TARGET_ADDRESS, b);
    rd(OFF_MASTER_DATA_REGISTER);
    chk(d, {24'h00_0000, b});
    if (f) begin
      rd(OFF_MASTER_STATUS_REGISTER);
      chk(d, 32'h0000_0002);
      chk({scl_oe_n, sda_oe_n}, 2'b11);
      ext_sda <= 1'b0;
    end
    poll(8'hC0, e & 8'hC0);
    chk(d, {24'h00_0000, e});
    chk(got, b);
    repeat (20) @(posedge aclk);
    chk(scl_oe_n, 1'b0);
    wr(OFF_MCMD, {6'h00, CMD_STOP});
    poll(8'h03, 8'h01);
    chk(d[1:0], BUS_IDLE);
    chk({scl_oe_n, sda_oe_n}, 2'b11);
    wr(OFF_MASTER_STATUS_REGISTER, 8'hC8);
    rd(OFF_MASTER_STATUS_REGISTER);
    chk(d, {24'h00_0000, 3'b000, e[4], 4'h1});
  endtask : t_addr
  // Another master pulls SDA during our first address bit, which is a one.
  task automatic t_collide;
    wr(OFF_MASTER_TARGET_ADDRESS, 8'hFE);
    wait (!scl_oe_n);
    @(posedge aclk);
    ext_sda <= 1'b1;
    poll(8'h08, 8'h08);
    chk(d, 32'h0000_004A);
    wr(OFF_MCTRL, 8'h05);
    poll(8'h03, 8'h01);
    chk(d, 32'h0000_0049);
    ext_sda <= 1'b0;
    wr(OFF_MASTER_STATUS_REGISTER, 8'hC8);
  endtask : t_collide
  task automatic t_disable;
    wr(OFF_MCTRL, 8'h00);
    rd(OFF_MASTER_STATUS_REGISTER);
    chk(d[1:0], BUS_UNKNOWN);
  endtask : t_disable
  task automatic complete_run;
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Main sequence and watchdog.
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_and_force();
    t_addr(8'hA4, 1'b1, 8'h63, 1'b0);
    rd(OFF_TCTRL);
    chk(d, 32'h0000_0081);
    t_addr(8'hA6, 1'b0, 8'h73, 1'b0);
    t_addr(8'hA5, 1'b1, 8'hA3, 1'b0);
    t_addr(8'hA4, 1'b1, 8'h63, 1'b1);
    t_collide();
    t_disable();
    complete_run();
  end
  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule : two_wire_bus_master_core_test
`default_nettype wire
